/* File: src/rstseq_pkg.sv */
// Purpose: shared constants for the reset sequencer
// Assumes: 25 MHz system clock, slow reference sampled as a pin
// Notes: offsets are word indices on the plain register port
package rstseq_pkg;
    // register offsets
    localparam logic [3:0] OFF_RESET_CAUSE = 4'h0;
    localparam logic [3:0] OFF_PORT_CTRL = 4'h1;
    localparam logic [3:0] OFF_CLOCK_CTRL = 4'h2;
    localparam logic [3:0] OFF_INTERCORE_CTRL = 4'h3;
    localparam logic [3:0] OFF_CMD_VECTOR = 4'h4;
    localparam logic [3:0] OFF_BOOT_STATUS = 4'h5;
    // reset_cause fields
    localparam int BIT_EXTERNAL_CAUSE = 0;
    localparam int BIT_WATCHDOG_CAUSE = 1;
    // port_control_reg fields
    localparam int BIT_SOFT_TURN_OFF = 15;
    localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
    // clock_control_reg fields
    localparam int BIT_SIG_CLK_SOURCE_SEL = 8;
    localparam int BIT_FAST_OUT_DISABLE = 7;
    localparam int BIT_CLK_OUT_DISABLE = 6;
    localparam int BIT_HOST_CLK_SELECT = 1;
    localparam int BIT_FAST_IN_DISABLE = 0;
    localparam logic [8:0] CLOCK_CTRL_RESET = 9'h000;
    // intercore / command vector fields
    localparam int BIT_SIG_HARD_RESET = 0;
    localparam int BIT_COMMAND_TRIGGER = 0;
    // boot
    localparam logic [31:0] EXT_BOOT_VECTOR = 32'h4000_0000;
    localparam logic [31:0] ROM_BOOT_VECTOR = 32'h0000_0000;
    localparam logic [3:0] CS0_WAIT_RESET = 4'hF;
    localparam logic CS0_PORT16_RESET = 1'b1;
    // timing counts in slow reference cycles; the signal hold counts on the selected reference
    localparam logic [2:0] EXT_QUALIFY_CYCLES = 3'h3;
    localparam logic [3:0] STRETCH_CYCLES = 4'h8;
    localparam logic [3:0] BOOT_LATCH_CYCLES = 4'h4;
    localparam logic [4:0] SIG_HOLD_CYCLES = 5'h10;
    localparam logic [1:0] SIG_CLK_DIV = 2'h2;
endpackage : rstseq_pkg

/* File: src/rstseq_top.sv */
// Purpose: qualify, stretch and record chip reset; sequence signal core reset
// Assumes: slow_ref_clk and fast_ref_clk well below half of clk
// Notes: time counts in slow or selected reference edges seen through a synchroniser
`timescale 1ns/1ns
module rstseq_top
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // reset sources
    input wire logic por_req,
    input wire logic wdog_timeout,
    input wire logic reset_in_n,
    input wire logic reset_alt_n,
    // reference clocks and straps
    input wire logic slow_ref_clk,
    input wire logic fast_ref_clk,
    input wire logic boot_select,
    input wire logic host_cycle,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // reset outputs
    output logic sys_reset_out_n,
    output logic sig_reset_out,
    output logic sig_cmd_irq,
    // clock steering
    output logic host_clk_from_slow,
    output logic sig_clk_from_slow,
    output logic clk_out_pin_en,
    output logic fast_clk_out_pin_en,
    output logic fast_in_buf_en,
    output logic sig_pll_enable,
    output logic [1:0] sig_clk_div,
    // boot control
    output logic rom_enable,
    output logic chip_select_zero,
    output logic [31:0] reset_vector,
    output logic [3:0] cs0_wait_states,
    output logic cs0_port_16bit,
    // port control
    output logic soft_turn_off,
    output logic [7:0] port_select
);

    // pin synchronisers
    logic [1:0] slow_sync_reg;
    logic [1:0] fast_sync_reg;
    logic [1:0] rstin_sync_reg;
    logic [1:0] rstalt_sync_reg;
    logic [1:0] boot_sync_reg;
    logic [1:0] por_sync_reg;
    logic slow_prev_reg;
    logic fast_prev_reg;
    logic slow_tick;
    logic fast_tick;

    // sequencing state
    logic [2:0] ext_cnt_reg;
    logic ext_qual;
    logic any_req;
    logic [3:0] stretch_cnt_reg;
    logic in_reset_reg;
    logic in_reset_next;
    logic [1:0] cause_reg;
    logic boot_ext_reg;
    logic first_pending_reg;
    logic [4:0] sig_cnt_reg;
    logic ref_tick;

    // software registers
    logic soft_turn_off_reg;
    logic [7:0] port_ctrl_reg;
    logic [8:0] clock_ctrl_reg;
    logic hard_reset_reg;
    logic wr_port;
    logic wr_clock;
    logic wr_intercore;
    logic wr_cmd;
    logic sig_clk_source_sel;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slow_sync_reg <= 2'h0;
            fast_sync_reg <= 2'h0;
            rstin_sync_reg <= 2'h3;
            rstalt_sync_reg <= 2'h3;
            boot_sync_reg <= 2'h0;
            por_sync_reg <= 2'h3;
            slow_prev_reg <= 1'b0;
            fast_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            slow_sync_reg <= {slow_sync_reg[0], slow_ref_clk};
            fast_sync_reg <= {fast_sync_reg[0], fast_ref_clk};
            rstin_sync_reg <= {rstin_sync_reg[0], reset_in_n};
            rstalt_sync_reg <= {rstalt_sync_reg[0], reset_alt_n};
            boot_sync_reg <= {boot_sync_reg[0], boot_select};
            por_sync_reg <= {por_sync_reg[0], por_req};
            slow_prev_reg <= slow_sync_reg[1];
            fast_prev_reg <= fast_sync_reg[1];
        end
    end

    assign slow_tick = slow_sync_reg[1] & ~slow_prev_reg;
    assign fast_tick = fast_sync_reg[1] & ~fast_prev_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ext_cnt_reg <= 3'h0;
        else if (clk_en)
        begin
            if (rstin_sync_reg[1] & rstalt_sync_reg[1])
                ext_cnt_reg <= 3'h0;
            else if (slow_tick & (ext_cnt_reg != rstseq_pkg::EXT_QUALIFY_CYCLES))
                ext_cnt_reg <= ext_cnt_reg + 3'h1;
        end
    end

    assign ext_qual = (ext_cnt_reg == rstseq_pkg::EXT_QUALIFY_CYCLES);
    assign any_req = ext_qual | wdog_timeout | por_sync_reg[1];

    // stretch counter reloads while any request stands
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stretch_cnt_reg <= rstseq_pkg::STRETCH_CYCLES;
        else if (clk_en)
        begin
            if (any_req)
                stretch_cnt_reg <= rstseq_pkg::STRETCH_CYCLES;
            // release after eight more slow edges
            else if (slow_tick & (stretch_cnt_reg != 4'h0))
                stretch_cnt_reg <= stretch_cnt_reg - 4'h1;
        end
    end

    always_comb
    begin
        in_reset_next = any_req | (stretch_cnt_reg != 4'h0);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            in_reset_reg <= 1'b1;
            sys_reset_out_n <= 1'b0;
        end
        else if (clk_en)
        begin
            in_reset_reg <= in_reset_next;
            sys_reset_out_n <= ~in_reset_next;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cause_reg <= 2'h0;
        else if (clk_en)
        begin
            if (ext_qual)
                cause_reg <= 2'h1;
            else if (wdog_timeout)
                cause_reg <= 2'h2;
            else if (por_sync_reg[1])
                cause_reg <= 2'h0;
        end
    end

    // strap caught four slow edges before release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            boot_ext_reg <= 1'b0;
        else if (clk_en)
        begin
            if (~any_req & slow_tick & (stretch_cnt_reg == rstseq_pkg::BOOT_LATCH_CYCLES))
                boot_ext_reg <= ~boot_sync_reg[1];
        end
    end

    // chip select zero only for the first host cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            first_pending_reg <= 1'b1;
        else if (clk_en)
        begin
            if (in_reset_next)
                first_pending_reg <= 1'b1;
            else if (host_cycle)
                first_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rom_enable <= 1'b1;
            chip_select_zero <= 1'b0;
            reset_vector <= rstseq_pkg::ROM_BOOT_VECTOR;
            cs0_wait_states <= rstseq_pkg::CS0_WAIT_RESET;
            cs0_port_16bit <= rstseq_pkg::CS0_PORT16_RESET;
        end
        else if (clk_en)
        begin
            rom_enable <= ~(boot_ext_reg & first_pending_reg);
            chip_select_zero <= boot_ext_reg & first_pending_reg & ~in_reset_reg;
            // high strap boots from internal ROM
            reset_vector <= boot_ext_reg ? rstseq_pkg::EXT_BOOT_VECTOR
                                         : rstseq_pkg::ROM_BOOT_VECTOR;
            if (in_reset_reg)
            begin
                cs0_wait_states <= rstseq_pkg::CS0_WAIT_RESET;
                cs0_port_16bit <= rstseq_pkg::CS0_PORT16_RESET;
            end
        end
    end

    assign wr_port = reg_wr & (reg_addr == rstseq_pkg::OFF_PORT_CTRL);
    assign wr_clock = reg_wr & (reg_addr == rstseq_pkg::OFF_CLOCK_CTRL);
    assign wr_intercore = reg_wr & (reg_addr == rstseq_pkg::OFF_INTERCORE_CTRL);
    assign wr_cmd = reg_wr & (reg_addr == rstseq_pkg::OFF_CMD_VECTOR);

    // only rst clears it, the power pin and other qualified resets do not
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            soft_turn_off_reg <= 1'b0;
        else if (clk_en & wr_port)
            soft_turn_off_reg <= reg_wdata[rstseq_pkg::BIT_SOFT_TURN_OFF];
    end

    // writes during reset are dropped: software is held anyway
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_ctrl_reg <= rstseq_pkg::PORT_CTRL_RESET;
            clock_ctrl_reg <= rstseq_pkg::CLOCK_CTRL_RESET;
        end
        else if (clk_en)
        begin
            if (in_reset_reg)
            begin
                port_ctrl_reg <= rstseq_pkg::PORT_CTRL_RESET;
                clock_ctrl_reg <= rstseq_pkg::CLOCK_CTRL_RESET;
            end
            else
            begin
                if (wr_port)
                    port_ctrl_reg <= reg_wdata[7:0];
                // source select lives in bit 8
                if (wr_clock)
                    clock_ctrl_reg <= reg_wdata[8:0];
            end
        end
    end

    // host hard reset and command trigger
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hard_reset_reg <= 1'b0;
            sig_cmd_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            if (in_reset_reg)
                hard_reset_reg <= 1'b0;
            else if (wr_intercore)
                hard_reset_reg <= reg_wdata[rstseq_pkg::BIT_SIG_HARD_RESET];
            sig_cmd_irq <= wr_cmd & ~in_reset_reg
                           & reg_wdata[rstseq_pkg::BIT_COMMAND_TRIGGER];
        end
    end

    assign sig_clk_source_sel = clock_ctrl_reg[rstseq_pkg::BIT_SIG_CLK_SOURCE_SEL];
    // fast reference is the default source
    assign ref_tick = sig_clk_source_sel ? slow_tick : fast_tick;

    // hold after release, counted on the selected reference
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sig_cnt_reg <= rstseq_pkg::SIG_HOLD_CYCLES;
        else if (clk_en)
        begin
            // every qualified reset reaches the signal core
            if (in_reset_reg | hard_reset_reg)
                sig_cnt_reg <= rstseq_pkg::SIG_HOLD_CYCLES;
            // absent fast clock never ticks, so it stays held
            else if (ref_tick & (sig_cnt_reg != 5'h00))
                sig_cnt_reg <= sig_cnt_reg - 5'h01;
        end
    end

    // reset forces slow clocks and enables clock pins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sig_reset_out <= 1'b1;
            host_clk_from_slow <= 1'b1;
            sig_clk_from_slow <= 1'b1;
            clk_out_pin_en <= 1'b1;
            fast_clk_out_pin_en <= 1'b1;
            fast_in_buf_en <= 1'b1;
            sig_pll_enable <= 1'b0;
            sig_clk_div <= rstseq_pkg::SIG_CLK_DIV;
        end
        else if (clk_en)
        begin
            sig_reset_out <= in_reset_reg | hard_reset_reg | (sig_cnt_reg != 5'h00);
            host_clk_from_slow <= in_reset_reg
                                  | ~clock_ctrl_reg[rstseq_pkg::BIT_HOST_CLK_SELECT];
            sig_clk_from_slow <= in_reset_reg | sig_clk_source_sel;
            clk_out_pin_en <= in_reset_reg
                              | ~clock_ctrl_reg[rstseq_pkg::BIT_CLK_OUT_DISABLE];
            fast_clk_out_pin_en <= in_reset_reg
                                   | ~clock_ctrl_reg[rstseq_pkg::BIT_FAST_OUT_DISABLE];
            fast_in_buf_en <= in_reset_reg | sig_clk_source_sel
                              | ~clock_ctrl_reg[rstseq_pkg::BIT_FAST_IN_DISABLE];
            sig_pll_enable <= 1'b0;
            sig_clk_div <= rstseq_pkg::SIG_CLK_DIV;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            soft_turn_off <= 1'b0;
            port_select <= rstseq_pkg::PORT_CTRL_RESET;
        end
        else if (clk_en)
        begin
            soft_turn_off <= soft_turn_off_reg;
            port_select <= port_ctrl_reg;
        end
    end

    // read data one cycle after the strobe, zero when idle or unmapped
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (clk_en)
        begin
            reg_rdata <= 16'h0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    rstseq_pkg::OFF_RESET_CAUSE:
                        reg_rdata <= {14'h0000, cause_reg};
                    rstseq_pkg::OFF_PORT_CTRL:
                        reg_rdata <= {soft_turn_off_reg, 7'h00, port_ctrl_reg};
                    rstseq_pkg::OFF_CLOCK_CTRL:
                        reg_rdata <= {7'h00, clock_ctrl_reg};
                    rstseq_pkg::OFF_INTERCORE_CTRL:
                        reg_rdata <= {15'h0000, hard_reset_reg};
                    rstseq_pkg::OFF_BOOT_STATUS:
                        reg_rdata <= {13'h0000, sig_reset_out, first_pending_reg, boot_ext_reg};
                    default:
                        reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule : rstseq_top

/* File: tb/rstseq_chk_sva.sv */
// Purpose: port-level checks of the reset sequencer
// Assumes: slow reference ticks are rising edges of slow_ref_clk
// Notes: bound to the design from the bench top file
`timescale 1ns/1ns
module rstseq_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stimulus seen
    input wire logic wdog_timeout,
    input wire logic slow_ref_clk,
    input wire logic host_cycle,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // responses seen
    input wire logic [15:0] reg_rdata,
    input wire logic sys_reset_out_n,
    input wire logic sig_reset_out,
    input wire logic sig_cmd_irq,
    input wire logic host_clk_from_slow,
    input wire logic sig_clk_from_slow,
    input wire logic clk_out_pin_en,
    input wire logic fast_clk_out_pin_en,
    input wire logic fast_in_buf_en,
    input wire logic sig_pll_enable,
    input wire logic [1:0] sig_clk_div,
    input wire logic rom_enable,
    input wire logic chip_select_zero,
    input wire logic [31:0] reset_vector,
    input wire logic [3:0] cs0_wait_states,
    input wire logic cs0_port_16bit,
    input wire logic soft_turn_off
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic slow_d;
    logic [4:0] low_ticks;
    // saturating count of slow ticks while the reset output is low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slow_d <= 1'b0;
            low_ticks <= 5'h0;
        end
        else
        begin
            slow_d <= slow_ref_clk;
            if (sys_reset_out_n)
                low_ticks <= 5'h0;
            else if (slow_ref_clk && !slow_d && low_ticks != 5'h1F)
                low_ticks <= low_ticks + 5'h1;
        end
    end
    a_wdog_acts_now: assert property (wdog_timeout |=> !sys_reset_out_n)
        else $error("watchdog request did not assert reset output");
    // one tick of slack covers the phase of the checker's own edge detect
    a_reset_min_width: assert property ($rose(sys_reset_out_n) |-> low_ticks >= 5'h7)
        else $error("reset output released too early");
    a_sig_held_after: assert property ($rose(sys_reset_out_n) |-> sig_reset_out [*8])
        else $error("signal core left reset with the system reset");
    a_slow_clocks_reset: assert property (!sys_reset_out_n && $past(!sys_reset_out_n) |->
        host_clk_from_slow && sig_clk_from_slow && clk_out_pin_en && fast_clk_out_pin_en
        && fast_in_buf_en)
        else $error("clock defaults not forced during reset");
    a_pll_off_div: assert property (!sig_pll_enable && sig_clk_div == 2'h2)
        else $error("signal clock not fast reference over two");
    a_cs0_defaults: assert property ($rose(sys_reset_out_n) |->
        cs0_wait_states == 4'hF && cs0_port_16bit)
        else $error("chip select zero defaults wrong");
    // the pending flag clears on the sampled host cycle, the outputs follow one clock later
    a_cs0_first_only: assert property (chip_select_zero && host_cycle |-> ##2
        !chip_select_zero && rom_enable)
        else $error("chip select zero held past first host cycle");
    a_cmd_trigger: assert property (reg_wr && reg_addr == 4'h4 && reg_wdata[0]
        && sys_reset_out_n |=> sig_cmd_irq ##1 !sig_cmd_irq)
        else $error("command trigger pulse missing or long");
    a_soft_off_kept: assert property ($fell(sys_reset_out_n) |-> $stable(soft_turn_off))
        else $error("soft turn-off changed by reset");
    a_cause_upper_zero: assert property (reg_rd && reg_addr == 4'h0 |=>
        reg_rdata[15:2] == 14'h0)
        else $error("cause register unused bits set");
    c_release: cover property ($rose(sys_reset_out_n));
    c_cmd_irq: cover property (sig_cmd_irq);
    c_first_cycle: cover property (chip_select_zero && host_cycle);
endmodule : rstseq_chk

/* File: tb/rstseq_board_model.sv */
// Purpose: board side of the sequencer: reference clocks, reset pins, strap
// Assumes: slow reference is clk/8, fast reference clk/4 when present
// Notes: an absent fast reference stands low rather than toggling
`timescale 1ns/1ns
module rstseq_board_model
(
    // clock
    input wire logic clk,
    // bench controls
    input wire logic fast_on,
    input wire logic boot_level,
    // board pins
    output logic slow_ref_clk,
    output logic fast_ref_clk,
    output logic reset_in_n,
    output logic reset_alt_n,
    output logic boot_select
);
    logic [2:0] div = 3'h0;
    initial
    begin
        slow_ref_clk = 1'b0;
        fast_ref_clk = 1'b0;
        reset_in_n = 1'b1;
        reset_alt_n = 1'b1;
    end
    always @(posedge clk)
    begin
        div <= div + 3'h1;
        slow_ref_clk <= div[2];
        fast_ref_clk <= fast_on & div[1];
    end
    // strap settled long before it is latched
    assign boot_select = boot_level;
    // low from mid-period, so exactly ticks rising edges see the pin low
    task automatic pulse(input int ticks, input logic alt);
        @(negedge slow_ref_clk);
        if (alt)
            reset_alt_n <= 1'b0;
        else
            reset_in_n <= 1'b0;
        repeat (ticks) @(negedge slow_ref_clk);
        reset_in_n <= 1'b1;
        reset_alt_n <= 1'b1;
    endtask : pulse
endmodule : rstseq_board_model

/* File: tb/rstseq_tb_top.sv */
// Purpose: directed tests of reset qualify, stretch, cause and signal core
// Assumes: clk 25 MHz, board model makes the reference clocks
// Notes: register access by one-cycle strobes, read data in next cycle
`timescale 1ns/1ns
module rstseq_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic por_req = 1'b0;
    logic wdog_timeout = 1'b0;
    logic host_cycle = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fast_on = 1'b1;
    logic boot_level = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata;
    logic slow_ref_clk, fast_ref_clk, reset_in_n, reset_alt_n, boot_select;
    logic sys_reset_out_n, sig_reset_out, sig_cmd_irq, host_clk_from_slow, sig_clk_from_slow;
    logic clk_out_pin_en, fast_clk_out_pin_en, fast_in_buf_en, sig_pll_enable, rom_enable;
    logic chip_select_zero, cs0_port_16bit, soft_turn_off;
    logic [1:0] sig_clk_div;
    logic [3:0] cs0_wait_states;
    logic [7:0] port_select;
    logic [31:0] reset_vector;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    rstseq_top dut (.clk, .rst, .clk_en, .por_req, .wdog_timeout, .reset_in_n, .reset_alt_n,
        .slow_ref_clk, .fast_ref_clk, .boot_select, .host_cycle, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .sys_reset_out_n, .sig_reset_out, .sig_cmd_irq,
        .host_clk_from_slow, .sig_clk_from_slow, .clk_out_pin_en, .fast_clk_out_pin_en,
        .fast_in_buf_en, .sig_pll_enable, .sig_clk_div, .rom_enable, .chip_select_zero,
        .reset_vector, .cs0_wait_states, .cs0_port_16bit, .soft_turn_off, .port_select);
    rstseq_board_model board (.clk, .fast_on, .boot_level, .slow_ref_clk, .fast_ref_clk,
        .reset_in_n, .reset_alt_n, .boot_select);
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(32'(d), 32'(exp));
    endtask : chk_reg
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // bounded wait for the reset output to come back high; n is the wait
    task automatic wait_release(output int n);
        n = 0;
        while (sys_reset_out_n !== 1'b1 && n < 400)
        begin
            settle(1);
            n++;
        end
        chk(32'(sys_reset_out_n), 32'h1);
    endtask : wait_release
    task automatic wdog_pulse();
        @(posedge clk);
        wdog_timeout <= 1'b1;
        @(posedge clk);
        wdog_timeout <= 1'b0;
        settle(2);
    endtask : wdog_pulse
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    initial
    begin
        int n;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle(2);
        wait_release(n);
        chk_reg(rstseq_pkg::OFF_RESET_CAUSE, 16'h0);
        chk(reset_vector, 32'h4000_0000);
        chk(32'({rom_enable, chip_select_zero}), 32'h1);
        chk(32'({cs0_wait_states, cs0_port_16bit}), 32'h1F);
        chk(32'(sig_reset_out), 32'h1);
        @(posedge clk);
        host_cycle <= 1'b1;
        @(posedge clk);
        host_cycle <= 1'b0;
        settle(1);
        chk(32'({rom_enable, chip_select_zero}), 32'h2);
        settle(100);
        chk(32'(sig_reset_out), 32'h0);
        $display("test 1 finished");
        board.pulse(2, 1'b0);
        settle(40);
        chk(32'(sys_reset_out_n), 32'h1);
        boot_level <= 1'b1;
        board.pulse(4, 1'b1);
        wait_release(n);
        chk(32'(n >= 52 && n <= 76), 32'h1);
        chk_reg(rstseq_pkg::OFF_RESET_CAUSE, 16'h1);
        chk(32'({rom_enable, chip_select_zero}), 32'h2);
        chk(reset_vector, 32'h0);
        $display("test 2 finished");
        wr(rstseq_pkg::OFF_PORT_CTRL, 16'h805A);
        settle(1);
        chk(32'({soft_turn_off, port_select}), 32'h15A);
        // a write while the enable is low must not land
        @(posedge clk);
        clk_en <= 1'b0;
        wr(rstseq_pkg::OFF_PORT_CTRL, 16'h0000);
        @(posedge clk);
        clk_en <= 1'b1;
        settle(1);
        chk(32'({soft_turn_off, port_select}), 32'h15A);
        settle(150);
        wdog_pulse();
        chk(32'({sys_reset_out_n, sig_reset_out}), 32'h1);
        wait_release(n);
        chk_reg(rstseq_pkg::OFF_RESET_CAUSE, 16'h2);
        chk(32'({soft_turn_off, port_select}), 32'h100);
        $display("test 3 finished");
        @(posedge clk);
        fork
            board.pulse(4, 1'b0);
            wdog_timeout <= 1'b1;
        join
        @(posedge clk);
        wdog_timeout <= 1'b0;
        wait_release(n);
        chk_reg(rstseq_pkg::OFF_RESET_CAUSE, 16'h1);
        wr(rstseq_pkg::OFF_RESET_CAUSE, 16'h2);
        chk_reg(rstseq_pkg::OFF_RESET_CAUSE, 16'h1);
        chk_reg(4'hF, 16'h0);
        $display("test 4 finished");
        settle(150);
        wr(rstseq_pkg::OFF_INTERCORE_CTRL, 16'h1);
        settle(1);
        chk(32'(sig_reset_out), 32'h1);
        wr(rstseq_pkg::OFF_CMD_VECTOR, 16'h1);
        chk(32'(sig_cmd_irq), 32'h1);
        wr(rstseq_pkg::OFF_INTERCORE_CTRL, 16'h0);
        settle(120);
        chk(32'(sig_reset_out), 32'h0);
        $display("test 5 finished");
        fast_on <= 1'b0;
        wdog_pulse();
        wait_release(n);
        settle(150);
        chk(32'(sig_reset_out), 32'h1);
        wr(rstseq_pkg::OFF_INTERCORE_CTRL, 16'h1);
        wr(rstseq_pkg::OFF_CLOCK_CTRL, 16'h0100);
        settle(1);
        chk(32'(sig_clk_from_slow), 32'h1);
        // hard reset held for 18 slow cycles before clearing
        repeat (18) @(posedge slow_ref_clk);
        wr(rstseq_pkg::OFF_INTERCORE_CTRL, 16'h0);
        settle(200);
        chk(32'(sig_reset_out), 32'h0);
        $display("test 6 finished");
        end_sim();
    end
endmodule : rstseq_tb_top
bind rstseq_top rstseq_chk u_chk (.clk, .rst, .wdog_timeout, .slow_ref_clk, .host_cycle,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_reset_out_n, .sig_reset_out,
    .sig_cmd_irq, .host_clk_from_slow, .sig_clk_from_slow, .clk_out_pin_en,
    .fast_clk_out_pin_en, .fast_in_buf_en, .sig_pll_enable, .sig_clk_div, .rom_enable,
    .chip_select_zero, .reset_vector, .cs0_wait_states, .cs0_port_16bit, .soft_turn_off);
